// file: isl_pkg.sv
// constants and types shared by both ends of the two-wire slave link
// Function
// - start sets the bus busy flag
// - only the master makes a start
// - seven bit address follows start, compared
// - address match sets flag and interrupt
// - eighth bit captured as read request
// - slave acks matched address on ninth clock
// - clock held until data access after match
// - one interrupt for match or byte done
// - direction one means slave transmits
// - firmware sets transmit select from direction
// - master stops after unacknowledged address
// - eight bit bytes, msb first
// - receiver acks each byte with low
// - transmitter releases data on master nack
// - bytes pass through the shared data register
// - receiver drives ack_to_send on ninth clock
// - transmitter records master ack, continues or stops
// - stop clears the bus busy flag
// - byte done low in transfer, high after
// - own address in bits seven to one
package isl_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // status byte field positions
  localparam int F_BYTE_DONE   = 7;
  localparam int F_ADDR_MATCH  = 6;
  localparam int F_BUS_BUSY    = 5;
  localparam int F_TX_SELECT   = 4;
  localparam int F_ACK_TO_SEND = 3;
  localparam int F_READ_REQ    = 2;
  localparam int F_ACK_RECV    = 0;
  // status reset values
  localparam logic RST_BYTE_DONE = 1'b1;
  localparam logic RST_ACK_RECV  = 1'b1;
  // master bus timing
  localparam int REF_PERIOD_NS   = 25;
  localparam int SCL_QUARTER_NS  = 1000;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} isl_op_type;
  typedef enum {D_IDLE, D_ADDR, D_ADDR_ACK, D_HOLD, D_RELEASE, D_DATA, D_DATA_ACK, D_IGNORE} isl_dev_state_type;
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} isl_mst_state_type;
endpackage

// file: isl_if.sv
// two-wire bus lines between master end and slave end
`timescale 1ns/1ps
interface isl_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic scl_s_o;
  logic scl_s_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up when nobody drives
  assign scl = (scl_m_oe ? scl_m_o : 1'b1) & (scl_s_oe ? scl_s_o : 1'b1);
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
  modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
  modport device (output scl_s_o, scl_s_oe, sda_s_o, sda_s_oe, input scl, sda);
endinterface

// file: isl_device.sv
// slave end: bus engine on link_clk, firmware side on ref_clk
`timescale 1ns/1ps
module isl_device
(
  // firmware clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // bus sampling clock
  input  wire logic       link_clk,
  // bus lines
  isl_if.device           bus,
  // firmware control
  input  wire logic [7:0] own_address_register,
  input  wire logic       slave_transmit_select,
  input  wire logic       ack_to_send,
  // data register access
  input  wire logic       data_wr,
  input  wire logic [7:0] data_wdata,
  input  wire logic       data_rd,
  output logic      [7:0] serial_data_register,
  // status and interrupt
  output logic      [7:0] serial_control_one,
  output logic            irq
);
  // ---------------- link domain ----------------
  isl_pkg::isl_dev_state_type st;
  logic       lrst_m;
  logic       link_rst_b;
  logic       scl_m;
  logic       scl_s;
  logic       scl_p;
  logic       sda_m;
  logic       sda_s;
  logic       sda_p;
  logic       rel_m;
  logic       rel_s;
  logic       rel_seen;
  logic       start_det;
  logic       stop_det;
  logic       scl_rise;
  logic       scl_fall;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic       tx_mode;
  logic       busy_l;
  logic       match_l;
  logic       rw_l;
  logic       nack_l;
  logic       ev_tgl;
  // ---------------- ref domain ----------------
  logic       ev_m;
  logic       ev_s;
  logic       ev_p;
  logic       busy_m;
  logic       bus_busy_flag;
  logic       rel_tgl;
  logic       pending;
  logic       hs_tx;
  logic       hs_ack;
  logic       byte_done_flag;
  logic       address_match_flag;
  logic       master_read_request_flag;
  logic       ack_received_flag;
  logic       event_now;
  logic       access;

  // open drain: only ever pull low
  assign bus.scl_s_o = 1'b0;
  assign bus.sda_s_o = 1'b0;

  // reset and line synchronisers into link domain
  always_ff @(posedge link_clk)
  begin
    lrst_m     <= rst_b;
    link_rst_b <= lrst_m;
    scl_m      <= bus.scl;
    scl_s      <= scl_m;
    sda_m      <= bus.sda;
    sda_s      <= sda_m;
    rel_m      <= rel_tgl;
    rel_s      <= rel_m;
  end

  // previous line samples for edge and condition detect
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_b)
    begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  // start: sda falls, stop: sda rises, both with scl high
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;

  // byte engine; data only changes while scl is low
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_b)
    begin
      st           <= isl_pkg::D_IDLE;
      bit_cnt      <= 4'h0;
      shreg        <= 8'h00;
      tx_mode      <= 1'b0;
      busy_l       <= 1'b0;
      match_l      <= 1'b0;
      rw_l         <= 1'b0;
      nack_l       <= isl_pkg::RST_ACK_RECV;
      ev_tgl       <= 1'b0;
      rel_seen     <= 1'b0;
      bus.scl_s_oe <= 1'b0;
      bus.sda_s_oe <= 1'b0;
    end
    else if (start_det)
    begin
      busy_l       <= 1'b1;
      st           <= isl_pkg::D_ADDR;
      bit_cnt      <= 4'h0;
      bus.scl_s_oe <= 1'b0;
      bus.sda_s_oe <= 1'b0;
    end
    else if (stop_det)
    begin
      busy_l       <= 1'b0;
      st           <= isl_pkg::D_IDLE;
      bus.scl_s_oe <= 1'b0;
      bus.sda_s_oe <= 1'b0;
    end
    else
    begin
      unique case (st)
        isl_pkg::D_IDLE, isl_pkg::D_IGNORE:
        begin
        end
        isl_pkg::D_ADDR:
        begin
          if (scl_rise)
          begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == isl_pkg::BITS_PER_BYTE)
          begin
            // address sits in bits 7:1 of own address
            if (shreg[7:1] == own_address_register[7:1])
            begin
              match_l      <= 1'b1;
              rw_l         <= shreg[0];
              bus.sda_s_oe <= 1'b1;
              st           <= isl_pkg::D_ADDR_ACK;
            end
            else
              st <= isl_pkg::D_IGNORE;
          end
        end
        isl_pkg::D_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            bus.sda_s_oe <= 1'b0;
            bus.scl_s_oe <= 1'b1;
            ev_tgl       <= ~ev_tgl;
            st           <= isl_pkg::D_HOLD;
          end
        end
        isl_pkg::D_HOLD:
        begin
          // firmware access frees the clock
          if (rel_s != rel_seen)
          begin
            rel_seen <= rel_s;
            tx_mode  <= hs_tx;
            bit_cnt  <= 4'h0;
            match_l  <= 1'b0;
            if (hs_tx)
            begin
              shreg        <= serial_data_register;
              bus.sda_s_oe <= ~serial_data_register[7];
            end
            st <= isl_pkg::D_RELEASE;
          end
        end
        isl_pkg::D_RELEASE:
        begin
          // one cycle gap so sda settles before scl rises
          bus.scl_s_oe <= 1'b0;
          st           <= isl_pkg::D_DATA;
        end
        isl_pkg::D_DATA:
        begin
          if (scl_rise)
          begin
            if (!tx_mode)
              shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (bit_cnt == isl_pkg::BITS_PER_BYTE)
            begin
              bus.sda_s_oe <= tx_mode ? 1'b0 : ~hs_ack;
              st           <= isl_pkg::D_DATA_ACK;
            end
            else if (tx_mode)
            begin
              shreg        <= {shreg[6:0], 1'b0};
              bus.sda_s_oe <= ~shreg[6];
            end
          end
        end
        isl_pkg::D_DATA_ACK:
        begin
          if (scl_rise && tx_mode)
            nack_l <= sda_s;
          else if (scl_fall)
          begin
            bus.sda_s_oe <= 1'b0;
            ev_tgl       <= ~ev_tgl;
            if (tx_mode && nack_l)
              st <= isl_pkg::D_IGNORE;
            else
            begin
              bus.scl_s_oe <= 1'b1;
              st           <= isl_pkg::D_HOLD;
            end
          end
        end
      endcase
    end
  end

  // event toggle and busy level into ref domain
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      ev_m          <= 1'b0;
      ev_s          <= 1'b0;
      ev_p          <= 1'b0;
      busy_m        <= 1'b0;
      bus_busy_flag <= 1'b0;
    end
    else
    begin
      ev_m          <= ev_tgl;
      ev_s          <= ev_m;
      ev_p          <= ev_s;
      busy_m        <= busy_l;
      bus_busy_flag <= busy_m;
    end
  end

  assign event_now = ev_s ^ ev_p;
  assign access    = (data_wr | data_rd) & pending;

  // firmware side flags; link state is frozen while an event is pending
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pending                  <= 1'b0;
      rel_tgl                  <= 1'b0;
      hs_tx                    <= 1'b0;
      hs_ack                   <= 1'b0;
      irq                      <= 1'b0;
      byte_done_flag           <= isl_pkg::RST_BYTE_DONE;
      address_match_flag       <= 1'b0;
      master_read_request_flag <= 1'b0;
      ack_received_flag        <= isl_pkg::RST_ACK_RECV;
    end
    else
    begin
      irq <= event_now;
      if (access)
      begin
        rel_tgl        <= ~rel_tgl;
        pending        <= 1'b0;
        byte_done_flag <= 1'b0;
        hs_tx          <= slave_transmit_select;
        hs_ack         <= ack_to_send;
      end
      // a new event wins over a same-cycle access
      if (event_now)
      begin
        pending            <= ~(hs_tx & nack_l & ~match_l);
        byte_done_flag     <= 1'b1;
        address_match_flag <= match_l;
        if (match_l)
          master_read_request_flag <= rw_l;
        ack_received_flag <= nack_l;
      end
    end
  end

  // shared data register: firmware writes, received bytes land here
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      serial_data_register <= 8'h00;
    else if (event_now && !match_l && !hs_tx)
      serial_data_register <= shreg;
    else if (data_wr)
      serial_data_register <= data_wdata;
  end

  // status byte view
  always_comb
  begin
    serial_control_one                         = 8'h00;
    serial_control_one[isl_pkg::F_BYTE_DONE]   = byte_done_flag;
    serial_control_one[isl_pkg::F_ADDR_MATCH]  = address_match_flag;
    serial_control_one[isl_pkg::F_BUS_BUSY]    = bus_busy_flag;
    serial_control_one[isl_pkg::F_TX_SELECT]   = slave_transmit_select;
    serial_control_one[isl_pkg::F_ACK_TO_SEND] = ack_to_send;
    serial_control_one[isl_pkg::F_READ_REQ]    = master_read_request_flag;
    serial_control_one[isl_pkg::F_ACK_RECV]    = ack_received_flag;
  end
endmodule

// file: isl_master.sv
// master end: makes start, stop and byte clocks from ref_clk
`timescale 1ns/1ps
module isl_master
#(
  parameter int QUARTER_CYC = isl_pkg::SCL_QUARTER_CYC
)
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  // bus lines
  isl_if.master                    bus,
  // command port
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire isl_pkg::isl_op_type cmd_op,
  input  wire logic [7:0]          cmd_data,
  // response
  output logic                     rsp_valid,
  output logic [7:0]               rsp_data,
  output logic                     rsp_nack
);
  isl_pkg::isl_mst_state_type st;
  isl_pkg::isl_op_type        op;
  logic       scl_m;
  logic       scl_s;
  logic       sda_m;
  logic       sda_s;
  logic [7:0] qcnt;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [8:0] tx;
  logic [8:0] rx;
  logic       tick;

  assign bus.scl_m_o = 1'b0;
  assign bus.sda_m_o = 1'b0;
  assign cmd_ready   = (st == isl_pkg::M_IDLE);
  assign tick        = (qcnt == 8'(QUARTER_CYC - 1));

  // line synchronisers
  always_ff @(posedge ref_clk)
  begin
    scl_m <= bus.scl;
    scl_s <= scl_m;
    sda_m <= bus.sda;
    sda_s <= sda_m;
  end

  // quarter period timer; stalls while the slave stretches scl
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || st == isl_pkg::M_IDLE)
      qcnt <= 8'h00;
    else if ((ph == 2'h1 && !scl_s) || tick)
      qcnt <= 8'h00;
    else
      qcnt <= qcnt + 8'h01;
  end

  // phase sequencer
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      st           <= isl_pkg::M_IDLE;
      op           <= isl_pkg::OP_STOP;
      ph           <= 2'h0;
      bitn         <= 4'h0;
      tx           <= 9'h1ff;
      rx           <= 9'h000;
      bus.scl_m_oe <= 1'b0;
      bus.sda_m_oe <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_data     <= 8'h00;
      rsp_nack     <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (st == isl_pkg::M_IDLE)
      begin
        if (cmd_valid)
        begin
          op   <= cmd_op;
          ph   <= 2'h0;
          bitn <= 4'h0;
          // read sends ones and drives ack low when cmd_data[0] is set
          tx   <= (cmd_op == isl_pkg::OP_READ) ? {8'hff, ~cmd_data[0]} : {cmd_data, 1'b1};
          unique case (cmd_op)
            isl_pkg::OP_START:
            begin
              bus.sda_m_oe <= 1'b0;
              st           <= isl_pkg::M_START;
            end
            isl_pkg::OP_STOP:
            begin
              bus.sda_m_oe <= 1'b1;
              rsp_nack     <= 1'b0;
              st           <= isl_pkg::M_STOP;
            end
            default:
            begin
              bus.sda_m_oe <= (cmd_op == isl_pkg::OP_READ) ? 1'b0 : ~cmd_data[7];
              st           <= isl_pkg::M_BIT;
            end
          endcase
        end
      end
      else if (tick)
      begin
        ph <= ph + 2'h1;
        unique case (st)
          isl_pkg::M_START:
          begin
            if (ph == 2'h0)
              bus.scl_m_oe <= 1'b0;
            else if (ph == 2'h1)
              bus.sda_m_oe <= 1'b1;
            else if (ph == 2'h2)
              bus.scl_m_oe <= 1'b1;
            else
            begin
              bus.sda_m_oe <= ~tx[8];
              st           <= isl_pkg::M_BIT;
            end
          end
          isl_pkg::M_BIT:
          begin
            if (ph == 2'h0)
              bus.scl_m_oe <= 1'b0;
            else if (ph == 2'h1)
              rx <= {rx[7:0], sda_s};
            else if (ph == 2'h2)
              bus.scl_m_oe <= 1'b1;
            else if (bitn == isl_pkg::BITS_PER_BYTE)
            begin
              rsp_data <= rx[8:1];
              rsp_nack <= rx[0];
              if (op == isl_pkg::OP_START && rx[0])
              begin
                bus.sda_m_oe <= 1'b1;
                st           <= isl_pkg::M_STOP;
              end
              else
              begin
                rsp_valid <= 1'b1;
                st        <= isl_pkg::M_IDLE;
              end
            end
            else
            begin
              bitn         <= bitn + 4'h1;
              tx           <= {tx[7:0], 1'b1};
              bus.sda_m_oe <= ~tx[7];
            end
          end
          isl_pkg::M_STOP:
          begin
            if (ph == 2'h0)
              bus.scl_m_oe <= 1'b0;
            else if (ph == 2'h1)
              bus.sda_m_oe <= 1'b0;
            else if (ph == 2'h3)
            begin
              rsp_valid <= 1'b1;
              st        <= isl_pkg::M_IDLE;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end
endmodule

// file: isl_props.sv
// wire-level assertions on the joined two-wire bus lines
`timescale 1ns/1ps
module isl_props
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // bus line enables and levels
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic scl_s_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // start and stop as seen on the resolved lines
  sequence seq_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence seq_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  // slave begins to pull data low
  sequence seq_slave_pull;
    $rose(sda_s_oe);
  endsequence

  // slave data only moves while the clock is low
  chk_slave_data_stable: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data moved while clock high");
  // a falling data edge under a high clock never comes from the slave
  chk_no_slave_start: assert property (seq_start |-> !$rose(sda_s_oe))
    else $error("slave produced a start");
  // after stop the slave has let go of both lines
  chk_stop_frees_slave: assert property (seq_stop |=> (!sda_s_oe && !scl_s_oe) [*8])
    else $error("slave still driving after stop");
  // clock hold only begins while the master already pulls low
  chk_hold_only_low: assert property ($rose(scl_s_oe) |-> !scl && scl_m_oe)
    else $error("slave clock hold started outside low phase");
  // receiver ack never fights the other end while clock is high
  chk_no_ack_fight: assert property (scl |-> !(sda_s_oe && sda_m_oe))
    else $error("both ends pull data in high phase");
  // all lines released right after reset
  chk_reset_idle: assert property ($rose(rst_b) |-> (!scl_m_oe && !sda_m_oe && !scl_s_oe && !sda_s_oe) [*8])
    else $error("line driven after reset");
  // a clock high phase lasts a while
  chk_scl_high_hold: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  // slave drive is sampled by a following clock rise
  chk_pull_sampled: assert property (seq_slave_pull |-> sda_s_oe throughout (##[1:400] $rose(scl)))
    else $error("slave drive not held to a clock rise");
endmodule

// file: i2c_slave_transfer_tb_top.sv
// bench joining master and slave ends over the two-wire bus
`timescale 1ns/1ps
module i2c_slave_transfer_tb_top;
  localparam int QC = 32;
  logic                ref_clk = 1'b0;
  logic                link_clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                cmd_valid = 1'b0;
  logic                cmd_ready;
  isl_pkg::isl_op_type cmd_op = isl_pkg::OP_STOP;
  logic [7:0]          cmd_data = 8'h00;
  logic                rsp_valid;
  logic [7:0]          rsp_data;
  logic                rsp_nack;
  logic [7:0]          own_address_register = 8'hb5; // address 5a, low bit set on purpose
  logic                slave_transmit_select = 1'b0;
  logic                ack_to_send = 1'b0;
  logic                data_wr = 1'b0;
  logic [7:0]          data_wdata = 8'h00;
  logic                data_rd = 1'b0;
  logic [7:0]          serial_data_register;
  logic [7:0]          serial_control_one;
  logic                irq;
  logic [7:0]          st;
  logic [7:0]          ev_q[$];
  logic [7:0]          rx_q[$];
  logic [7:0]          tx_q[$];
  int                  ack_cnt = 1;
  int                  fails = 0;
  int                  checked = 0;

  // clocks, link clock unrelated in phase
  always #12.5 ref_clk = ~ref_clk;
  always #80 link_clk = ~link_clk;

  // both ends and the wire checker
  isl_if isl_if_i ();
  isl_master #(.QUARTER_CYC(QC)) isl_master_i (.ref_clk, .rst_b, .bus(isl_if_i), .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_data, .rsp_valid, .rsp_data, .rsp_nack);
  isl_device isl_device_i (.ref_clk, .rst_b, .link_clk, .bus(isl_if_i), .own_address_register,
    .slave_transmit_select, .ack_to_send, .data_wr, .data_wdata, .data_rd, .serial_data_register,
    .serial_control_one, .irq);
  isl_props isl_props_i (.ref_clk, .rst_b, .scl_m_oe(isl_if_i.scl_m_oe), .sda_m_oe(isl_if_i.sda_m_oe),
    .scl_s_oe(isl_if_i.scl_s_oe), .sda_s_oe(isl_if_i.sda_s_oe), .scl(isl_if_i.scl), .sda(isl_if_i.sda));

  // compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one master command, waits for its answer
  task automatic mst(input isl_pkg::isl_op_type op, input logic [7:0] d);
    int n;
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_data  <= d;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1)
      @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 20000);
    if (n >= 20000)
      chk("answer timeout", 8'h01, 8'h00);
  endtask

  // one releasing data access, write or dummy read
  task automatic fw_access(input logic wr);
    if (wr)
    begin
      data_wr    <= 1'b1;
      data_wdata <= tx_q.pop_front();
    end
    else
      data_rd <= 1'b1;
    @(posedge ref_clk);
    data_wr <= 1'b0;
    data_rd <= 1'b0;
  endtask

  // firmware handler: logs each event and answers all but a master nack
  always @(posedge ref_clk)
  begin
    if (irq === 1'b1)
    begin
      st = serial_control_one;
      ev_q.push_back(st);
      if (st[6] === 1'b1)
      begin
        slave_transmit_select <= st[2]; // role follows direction
        fw_access(st[2]);
      end
      else if (slave_transmit_select === 1'b0)
      begin
        rx_q.push_back(serial_data_register);
        ack_to_send <= (rx_q.size() >= ack_cnt); // refuse bytes past the count
        fw_access(1'b0);
      end
      else if (st[0] === 1'b0)
        fw_access(1'b1);
    end
  end

  // watchdog on a hung run
  initial
  begin
    #(60000 * 25);
    fails++;
    summarize();
  end

  // foreign address, then a write of two bytes, then a read of two bytes
  initial
  begin
    repeat (32) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk("status after reset", serial_control_one, 8'h81);
    mst(isl_pkg::OP_START, 8'h67);
    chk("foreign address nack", {7'h00, rsp_nack}, 8'h01);
    chk("foreign address events", 8'(ev_q.size()), 8'h00);
    mst(isl_pkg::OP_START, 8'hb4);
    chk("address ack", {7'h00, rsp_nack}, 8'h00);
    mst(isl_pkg::OP_WRITE, 8'hc3);
    chk("first byte ack", {7'h00, rsp_nack}, 8'h00);
    mst(isl_pkg::OP_WRITE, 8'h5e);
    chk("second byte nack", {7'h00, rsp_nack}, 8'h01);
    chk("busy in transfer", {7'h00, serial_control_one[5]}, 8'h01);
    mst(isl_pkg::OP_STOP, 8'h00);
    repeat (20) @(posedge ref_clk);
    chk("busy after stop", {7'h00, serial_control_one[5]}, 8'h00);
    chk("write events", 8'(ev_q.size()), 8'h03);
    chk("match event", ev_q[0] & 8'he4, 8'he0);
    chk("byte event", ev_q[1] & 8'hc0, 8'h80);
    chk("first byte", rx_q[0], 8'hc3);
    chk("second byte", rx_q[1], 8'h5e);
    ev_q.delete();
    tx_q.push_back(8'ha5);
    tx_q.push_back(8'h3c);
    mst(isl_pkg::OP_START, 8'hb5);
    chk("read address ack", {7'h00, rsp_nack}, 8'h00);
    mst(isl_pkg::OP_READ, 8'h01);
    chk("first sent byte", rsp_data, 8'ha5);
    mst(isl_pkg::OP_READ, 8'h00);
    chk("second sent byte", rsp_data, 8'h3c);
    mst(isl_pkg::OP_STOP, 8'h00);
    repeat (20) @(posedge ref_clk);
    chk("transmit select echo", {7'h00, serial_control_one[4]}, 8'h01);
    chk("busy after read stop", {7'h00, serial_control_one[5]}, 8'h00);
    chk("read events", 8'(ev_q.size()), 8'h03);
    chk("read request event", ev_q[0] & 8'h44, 8'h44);
    chk("master ack seen", ev_q[1] & 8'h81, 8'h80);
    chk("master nack seen", ev_q[2] & 8'h81, 8'h81);
    summarize();
  end
endmodule
